// ### common/pcreg_map.svh
// register offsets, field positions and reset values of the processor control registers
`ifndef PCREG_MAP_SVH
`define PCREG_MAP_SVH

`define PCREG_OFS_FLAGS     16'hc000
`define PCREG_OFS_WBASE     16'hc002
`define PCREG_OFS_REV       16'hc004
`define PCREG_OFS_CDIV      16'hc008
`define PCREG_OFS_PWR       16'hc00a
`define PCREG_OFS_IEN       16'hc00e
`define PCREG_OFS_BKPT      16'hc014
`define PCREG_OFS_DIAG      16'hc03c

`define PCREG_FLAG_GIE      4
`define PCREG_FLAG_NEG      3
`define PCREG_FLAG_OVF      2
`define PCREG_FLAG_CRY      1
`define PCREG_FLAG_ZER      0
`define PCREG_FLAG_MASK     16'h001f

`define PCREG_WBASE_MASK    16'hfff0
`define PCREG_WBASE_RST     16'h0100
`define PCREG_CDIV_MASK     16'h000f
`define PCREG_CDIV_RST      4'hf
`define PCREG_REV_DEFAULT   16'h0a5c
`define PCREG_ZERO16        16'h0000

`endif

// ### common/pcreg_pkg.sv
// types shared by the processor control register block
package pcreg_pkg;

   // live status from the cpu core
   typedef struct packed {
      logic gie;
      logic neg;
      logic ovf;
      logic cry;
      logic zer;
   } pcreg_flags_t;

   // working register address request and answer
   typedef struct packed {
      logic [3:0]  regnum;
      logic [15:0] ram_addr;
   } pcreg_wreg_t;

   // divider states
   typedef enum logic [0:0] {
      PCREG_DIV_RUN,
      PCREG_DIV_RELOAD
   } pcreg_div_state_t;

endpackage

// ### rtl/pcreg_cpu_clkdiv.sv
// cpu clock enable divider, field n gives one pulse every n+1 cycles
`timescale 1ns/10ps
`include "pcreg_map.svh"
module pcreg_cpu_clkdiv
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // divisor field
   input  wire logic [3:0] div,
   // cpu enable pulse
   output wire logic       cpu_ce
);
   logic [3:0]                   cnt_r;
   logic [3:0]                   cnt_nxt;
   pcreg_pkg::pcreg_div_state_t  st_r;
   pcreg_pkg::pcreg_div_state_t  st_nxt;
   wire                          hit;

   // pulse when counter reaches the divisor
   assign hit    = (cnt_r >= div);
   assign cpu_ce = hit;

   // next state and count
   always_comb
   begin
      cnt_nxt = cnt_r + 4'h1;
      st_nxt  = pcreg_pkg::PCREG_DIV_RUN;
      case (st_r)
         pcreg_pkg::PCREG_DIV_RUN:
         begin
            if (hit)
            begin
               cnt_nxt = 4'h0;
               st_nxt  = pcreg_pkg::PCREG_DIV_RELOAD;
            end
         end
         pcreg_pkg::PCREG_DIV_RELOAD:
         begin
            if (hit)
               cnt_nxt = 4'h0;
         end
         default:
            cnt_nxt = 4'h0;
      endcase
   end

   // counter register
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cnt_r <= 4'h0;
         st_r  <= pcreg_pkg::PCREG_DIV_RUN;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         st_r  <= st_nxt;
      end
   end

   // pulse at divisor three, then three more cycles at that divisor
   sequence s_div3_run;
      (cpu_ce && div == 4'h3 && $stable(div)) ##1 (div == 4'h3)[*3];
   endsequence

   // quiet in the two cycles before the next pulse
   sequence s_div3_gap;
      !cpu_ce ##0 $past(!cpu_ce) ##1 cpu_ce;
   endsequence

   // spacing of enable pulses at divisor three equals div plus one
   a_div_spacing: assert property (@(posedge clk) disable iff (!rstn)
      s_div3_run |-> s_div3_gap)
      else $error("cpu enable spacing wrong");
endmodule

// ### rtl/pcreg_top.sv
// processor control register bank on a classic wishbone slave
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
`include "pcreg_map.svh"
module pcreg_top
#(
   parameter logic [15:0] REVISION = `PCREG_REV_DEFAULT // arbitrary value
)
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rstn,
   // wishbone slave
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [15:0]               wb_adr_i,
   input  wire logic [1:0]                wb_sel_i,
   input  wire logic [15:0]               wb_dat_i,
   output logic      [15:0]               wb_dat_o,
   output logic                           wb_ack_o,
   output logic                           wb_err_o,
   // live cpu status
   input  wire pcreg_pkg::pcreg_flags_t   cpu_flags,
   // working register address generation
   input  wire logic [3:0]                wreg_num,
   output logic      [15:0]               wreg_ram_addr,
   // cpu clock enable and peripheral enable
   output wire logic                      cpu_ce,
   output wire logic                      periph_ce,
   // control register contents
   output logic      [15:0]               power_ctrl,
   output logic      [15:0]               irq_enables,
   output logic      [15:0]               bkpt_addr,
   output logic      [15:0]               diag_ctrl,
   output logic                           diag_wr
);
   logic [15:0] wbase_r;
   logic [3:0]  cdiv_r;
   logic [15:0] pwr_r;
   logic [15:0] ien_r;
   logic [15:0] bkpt_r;
   logic [15:0] diag_r;
   logic        diag_wr_r;
   logic [15:0] rdat_r;
   logic        ack_r;
   logic        err_r;
   logic [15:0] wreg_addr_r;
   wire  [15:0] wreg_addr_w;
   wire  [15:0] wmask;
   wire  [15:0] wdat;
   wire         req;
   wire         hit_flags;
   wire         hit_wbase;
   wire         hit_rev;
   wire         hit_cdiv;
   wire         hit_pwr;
   wire         hit_ien;
   wire         hit_bkpt;
   wire         hit_diag;
   wire         mapped;
   wire         wr;
   wire         rd_only;
   wire  [15:0] flags_word;
   wire  [15:0] rmux;

   // new request, not yet answered
   assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;

   // address decode
   assign hit_flags = (wb_adr_i == `PCREG_OFS_FLAGS);
   assign hit_wbase = (wb_adr_i == `PCREG_OFS_WBASE);
   assign hit_rev   = (wb_adr_i == `PCREG_OFS_REV);
   assign hit_cdiv  = (wb_adr_i == `PCREG_OFS_CDIV);
   assign hit_pwr   = (wb_adr_i == `PCREG_OFS_PWR);
   assign hit_ien   = (wb_adr_i == `PCREG_OFS_IEN);
   assign hit_bkpt  = (wb_adr_i == `PCREG_OFS_BKPT);
   assign hit_diag  = (wb_adr_i == `PCREG_OFS_DIAG);
   assign mapped    = hit_flags | hit_wbase | hit_rev | hit_cdiv
                    | hit_pwr | hit_ien | hit_bkpt | hit_diag;
   assign rd_only   = hit_flags | hit_rev;
   assign wr        = req && wb_we_i && mapped && !rd_only;

   // byte lane mask and merged write data
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // live flag word, reserved bits zero
   assign flags_word = {11'h000,
                        cpu_flags.gie,
                        cpu_flags.neg,
                        cpu_flags.ovf,
                        cpu_flags.cry,
                        cpu_flags.zer};
   assign wdat = wb_dat_i & wmask;

   // read mux, diagnostic is write-only and reads zero
   assign rmux = hit_flags ? (flags_word & `PCREG_FLAG_MASK) :
                 hit_wbase ? wbase_r :
                 hit_rev   ? REVISION :
                 hit_cdiv  ? {12'h000, cdiv_r} :
                 hit_pwr   ? pwr_r :
                 hit_ien   ? ien_r :
                 hit_bkpt  ? bkpt_r :
                 `PCREG_ZERO16;

   // bus answer, one cycle after the request
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ack_r  <= 1'b0;
         err_r  <= 1'b0;
         rdat_r <= `PCREG_ZERO16;
      end
      else
      begin
         ack_r  <= req && mapped;
         err_r  <= req && !mapped;
         rdat_r <= (req && mapped && !wb_we_i) ? rmux : `PCREG_ZERO16;
      end
   end

   // window base, only bits 15..4 stored
   always_ff @(posedge clk)
   begin
      if (!rstn)
         wbase_r <= `PCREG_WBASE_RST;
      else if (wr && hit_wbase)
         wbase_r <= (wbase_r & ~wmask) | (wdat & `PCREG_WBASE_MASK);
   end

   // cpu speed field, low byte lane only
   always_ff @(posedge clk)
   begin
      if (!rstn)
         cdiv_r <= `PCREG_CDIV_RST;
      else if (wr && hit_cdiv && wb_sel_i[0])
         cdiv_r <= wb_dat_i[3:0];
   end

   // plain storage registers
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pwr_r  <= `PCREG_ZERO16;
         ien_r  <= `PCREG_ZERO16;
         bkpt_r <= `PCREG_ZERO16;
      end
      else
      begin
         if (wr && hit_pwr)
            pwr_r <= (pwr_r & ~wmask) | wdat;
         if (wr && hit_ien)
            ien_r <= (ien_r & ~wmask) | wdat;
         if (wr && hit_bkpt)
            bkpt_r <= (bkpt_r & ~wmask) | wdat;
      end
   end

   // write-only diagnostic register and its strobe
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         diag_r    <= `PCREG_ZERO16;
         diag_wr_r <= 1'b0;
      end
      else
      begin
         diag_wr_r <= wr && hit_diag;
         if (wr && hit_diag)
            diag_r <= (diag_r & ~wmask) | wdat;
      end
   end

   // working register address, registered
   pcreg_wreg_addr u_wreg
   (
      .base     (wbase_r),
      .regnum   (wreg_num),
      .ram_addr (wreg_addr_w)
   );

   always_ff @(posedge clk)
   begin
      if (!rstn)
         wreg_addr_r <= `PCREG_WBASE_RST;
      else
         wreg_addr_r <= wreg_addr_w;
   end

   // cpu-only clock enable; peripherals keep the full rate
   pcreg_cpu_clkdiv u_div
   (
      .clk    (clk),
      .rstn   (rstn),
      .div    (cdiv_r),
      .cpu_ce (cpu_ce)
   );
   assign periph_ce = 1'b1;

   // outputs
   assign wb_dat_o      = rdat_r;
   assign wb_ack_o      = ack_r;
   assign wb_err_o      = err_r;
   assign wreg_ram_addr = wreg_addr_r;
   assign power_ctrl    = pwr_r;
   assign irq_enables   = ien_r;
   assign bkpt_addr     = bkpt_r;
   assign diag_ctrl     = diag_r;
   assign diag_wr       = diag_wr_r;

   // read of flags returns live bits one cycle later
   a_flags_read: assert property (@(posedge clk) disable iff (!rstn)
      (req && !wb_we_i && hit_flags) |=> (wb_ack_o && wb_dat_o[15:5] == 11'h000
      && wb_dat_o[4:0] == $past(cpu_flags)))
      else $error("flags read wrong");

   // read-only write leaves state alone
   a_ro_write: assert property (@(posedge clk) disable iff (!rstn)
      (req && wb_we_i && rd_only) |=> ($stable(wbase_r) && $stable(cdiv_r) && $stable(pwr_r)))
      else $error("read-only write disturbed state");

   // base low bits stay zero
   a_wbase_low: assert property (@(posedge clk) disable iff (!rstn)
      wbase_r[3:0] == 4'h0)
      else $error("window base reserved bits set");

   // address generation relation, once the generator has left reset
   a_wreg_addr: assert property (@(posedge clk) disable iff (!rstn)
      rstn |=> wreg_ram_addr == (($past(wbase_r) & `PCREG_WBASE_MASK)
      | {11'h000, $past(wreg_num), 1'b0}))
      else $error("working register address wrong");

   // revision read
   a_rev_read: assert property (@(posedge clk) disable iff (!rstn)
      (req && !wb_we_i && hit_rev) |=> wb_dat_o == REVISION)
      else $error("revision read wrong");

   // divider write takes effect
   a_cdiv_write: assert property (@(posedge clk) disable iff (!rstn)
      (wr && hit_cdiv && wb_sel_i[0]) |=> cdiv_r == $past(wb_dat_i[3:0]))
      else $error("speed field write lost");

   // error without ack, for one cycle only
   sequence s_err_once;
      (wb_err_o && !wb_ack_o) ##1 !wb_err_o;
   endsequence

   // unmapped address gives error not ack
   a_unmapped: assert property (@(posedge clk) disable iff (!rstn)
      (req && !mapped) |=> s_err_once)
      else $error("unmapped access answered wrong");

   // diag strobe follows a diag write
   a_diag_strobe: assert property (@(posedge clk) disable iff (!rstn)
      (wr && hit_diag) |=> (diag_wr && diag_ctrl == (($past(diag_r) & ~$past(wmask))
      | $past(wdat))))
      else $error("diagnostic write wrong");

   // peripheral enable never divided
   a_periph_full: assert property (@(posedge clk) disable iff (!rstn)
      periph_ce)
      else $error("peripheral rate divided");
endmodule

// ### rtl/pcreg_wreg_addr.sv
// working register ram address generator
`timescale 1ns/10ps
`include "pcreg_map.svh"
module pcreg_wreg_addr
(
   // window base
   input  wire logic [15:0] base,
   // register number
   input  wire logic [3:0]  regnum,
   // ram address
   output wire logic [15:0] ram_addr
);
   // shift number left, or with base, force lsb low
   assign ram_addr = (base & `PCREG_WBASE_MASK) | {11'h000, regnum, 1'b0};
endmodule

// ### tb/pcreg_top_tb_top.sv
// self-checking bench for the processor control register bank
`timescale 1ns/10ps
`include "pcreg_map.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module pcreg_top_tb_top;
   // arbitrary revision value for this bench
   localparam logic [15:0] REV = 16'h3c5a;
   logic                    clk;
   logic                    rstn;
   logic                    wb_cyc_i;
   logic                    wb_stb_i;
   logic                    wb_we_i;
   logic [15:0]             wb_adr_i;
   logic [1:0]              wb_sel_i;
   logic [15:0]             wb_dat_i;
   logic [15:0]             wb_dat_o;
   logic                    wb_ack_o;
   logic                    wb_err_o;
   pcreg_pkg::pcreg_flags_t cpu_flags;
   logic [3:0]              wreg_num;
   logic [15:0]             wreg_ram_addr;
   logic                    cpu_ce;
   logic                    periph_ce;
   logic [15:0]             power_ctrl;
   logic [15:0]             irq_enables;
   logic [15:0]             bkpt_addr;
   logic [15:0]             diag_ctrl;
   logic                    diag_wr;
   int                      miscompares = 0;
   int                      check_count = 0;
   int                      cycles = 0;
   int                      diag_pulses = 0;
   logic [1:0]              lanes = 2'h3;

   pcreg_top #(.REVISION(REV)) pcreg_top_i (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .cpu_flags(cpu_flags), .wreg_num(wreg_num), .wreg_ram_addr(wreg_ram_addr),
      .cpu_ce(cpu_ce), .periph_ce(periph_ce), .power_ctrl(power_ctrl),
      .irq_enables(irq_enables), .bkpt_addr(bkpt_addr), .diag_ctrl(diag_ctrl),
      .diag_wr(diag_wr));

   // 25 mhz clock
   initial clk = 1'b0;
   always #20 clk = ~clk;

   // cycle ceiling and diagnostic pulse counter
   always @(posedge clk)
   begin
      cycles++;
      if (diag_wr === 1'b1) diag_pulses++;
      if (cycles == 20000)
      begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one classic wishbone cycle, held until ack or err is sampled
   task automatic wb(input logic we, input logic [15:0] adr, input logic [15:0] dat,
                     output logic [15:0] rd, output logic er);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= lanes;
      wb_dat_i <= dat;
      do
      begin
         @(posedge clk);
      end
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] adr, input logic [15:0] dat);
      logic [15:0] rd;
      logic        er;
      wb(1'b1, adr, dat, rd, er);
      `CHK(er, 1'b0)
   endtask

   task automatic rdchk(input logic [15:0] adr, input logic [15:0] exp);
      logic [15:0] rd;
      logic        er;
      wb(1'b0, adr, 16'h0000, rd, er);
      `CHK(rd, exp)
   endtask

   // reset values of every readable register and of the address generator
   task automatic t_reset();
      rdchk(`PCREG_OFS_WBASE, 16'h0100);
      rdchk(`PCREG_OFS_CDIV, 16'h000f);
      rdchk(`PCREG_OFS_REV, REV);
      rdchk(`PCREG_OFS_FLAGS, 16'h0000);
      rdchk(`PCREG_OFS_PWR, 16'h0000);
      rdchk(`PCREG_OFS_IEN, 16'h0000);
      rdchk(`PCREG_OFS_BKPT, 16'h0000);
      `CHK(wreg_ram_addr, 16'h0100)
   endtask

   // each live flag alone, then all, reserved bits zero
   task automatic t_flags();
      for (int i = 0; i < 5; i++)
      begin
         cpu_flags <= 5'h01 << i;
         rdchk(`PCREG_OFS_FLAGS, 16'h0001 << i);
      end
      cpu_flags <= 5'h1f;
      rdchk(`PCREG_OFS_FLAGS, 16'h001f);
   endtask

   // writes to read-only places and reserved bits change nothing
   task automatic t_readonly();
      cpu_flags <= 5'h0a;
      wr(`PCREG_OFS_FLAGS, 16'hffff);
      rdchk(`PCREG_OFS_FLAGS, 16'h000a);
      wr(`PCREG_OFS_REV, ~REV);
      rdchk(`PCREG_OFS_REV, REV);
      wr(`PCREG_OFS_CDIV, 16'hfff5);
      rdchk(`PCREG_OFS_CDIV, 16'h0005);
   endtask

   // window base field and working register address forming
   task automatic t_window();
      wreg_num <= 4'he;
      repeat (2) @(posedge clk);
      `CHK(wreg_ram_addr, 16'h011c)
      wr(`PCREG_OFS_WBASE, 16'habcf);
      rdchk(`PCREG_OFS_WBASE, 16'habc0);
      wreg_num <= 4'h5;
      repeat (2) @(posedge clk);
      `CHK(wreg_ram_addr, 16'habca)
      wreg_num <= 4'hf;
      repeat (2) @(posedge clk);
      `CHK(wreg_ram_addr, 16'habde)
   endtask

   // cpu enable period follows the divisor, peripherals stay at full rate
   task automatic t_speed();
      logic [3:0] divs [3] = '{4'h0, 4'h3, 4'hf};
      int         g;
      foreach (divs[d])
      begin
         wr(`PCREG_OFS_CDIV, {12'h000, divs[d]});
         for (int k = 0; k < 3; k++)
         begin
            g = 0;
            do
            begin
               @(posedge clk);
               g++;
               `CHK(periph_ce, 1'b1)
            end
            while (cpu_ce !== 1'b1 && g < 40);
         end
         `CHK(g, int'(divs[d]) + 1)
      end
   endtask

   // plain read/write registers, write-only diagnostic, unmapped address
   task automatic t_regs();
      logic [15:0] rd;
      logic        er;
      int          p;
      wr(`PCREG_OFS_PWR, 16'h5a13);
      wr(`PCREG_OFS_IEN, 16'h1b97);
      wr(`PCREG_OFS_BKPT, 16'hc3e1);
      rdchk(`PCREG_OFS_PWR, 16'h5a13);
      rdchk(`PCREG_OFS_IEN, 16'h1b97);
      rdchk(`PCREG_OFS_BKPT, 16'hc3e1);
      `CHK(power_ctrl, 16'h5a13)
      `CHK(irq_enables, 16'h1b97)
      `CHK(bkpt_addr, 16'hc3e1)
      p = diag_pulses;
      wr(`PCREG_OFS_DIAG, 16'h7e42);
      repeat (2) @(posedge clk);
      `CHK(diag_pulses, p + 1)
      `CHK(diag_ctrl, 16'h7e42)
      rdchk(`PCREG_OFS_DIAG, 16'h0000);
      wb(1'b0, 16'hc006, 16'h0000, rd, er);
      `CHK(er, 1'b1)
      `CHK(wb_ack_o, 1'b0)
   endtask

   // single byte lanes; the speed field needs the low lane
   task automatic t_lanes();
      lanes = 2'h1;
      wr(`PCREG_OFS_BKPT, 16'h1234);
      rdchk(`PCREG_OFS_BKPT, 16'hc334);
      wr(`PCREG_OFS_CDIV, 16'h0007);
      rdchk(`PCREG_OFS_CDIV, 16'h0007);
      lanes = 2'h2;
      wr(`PCREG_OFS_CDIV, 16'h0003);
      rdchk(`PCREG_OFS_CDIV, 16'h0007);
      wr(`PCREG_OFS_WBASE, 16'h2200);
      rdchk(`PCREG_OFS_WBASE, 16'h22c0);
      lanes = 2'h3;
   endtask

   // reset in mid-run brings every stored value back
   task automatic t_rereset();
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      `CHK(wb_ack_o, 1'b0)
      `CHK(power_ctrl, 16'h0000)
      `CHK(irq_enables, 16'h0000)
      `CHK(bkpt_addr, 16'h0000)
      `CHK(diag_ctrl, 16'h0000)
      rdchk(`PCREG_OFS_WBASE, 16'h0100);
      rdchk(`PCREG_OFS_CDIV, 16'h000f);
      `CHK(wreg_ram_addr, 16'h011e)
   endtask

   // main sequence
   initial
   begin
      rstn      = 1'b0;
      wb_cyc_i  = 1'b0;
      wb_stb_i  = 1'b0;
      wb_we_i   = 1'b0;
      wb_adr_i  = 16'h0000;
      wb_sel_i  = 2'h3;
      wb_dat_i  = 16'h0000;
      cpu_flags = 5'h00;
      wreg_num  = 4'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_flags();
      t_readonly();
      t_window();
      t_speed();
      t_regs();
      t_lanes();
      t_rereset();
      conclude();
   end
endmodule
